// *** core/psq_core.sv ***
// Stroke sequencing, speed ramping and fault supervision of the press drive
`timescale 1ns/10ps
module psq_core #(
  parameter int P_CYC_PER_MS = psq_pkg::CYC_PER_MS
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Press control pins
  input wire psq_pkg::psq_pins_type i_pins,
  // Position and measurements
  input wire logic [8:0] i_resolver_deg,
  input wire psq_pkg::psq_meas_type i_meas,
  // Settings
  input wire psq_pkg::psq_profile_type i_profile,
  input wire psq_pkg::psq_rate_type i_rates,
  input wire psq_pkg::psq_times_type i_times,
  input wire logic i_clear_fault,
  // Drive outputs
  output logic [8:0] o_position,
  output logic [11:0] o_setpoint,
  output logic o_clutch_contactor,
  output logic o_normal_stop,
  // Fault record
  output logic o_fault_active,
  output logic [psq_pkg::HIST-1:0][8:0] o_fault_hist
);
  import psq_pkg::*;

  localparam int MSW = $clog2(P_CYC_PER_MS);

  function automatic logic [8:0] wrap_deg(input logic [9:0] s);
    wrap_deg = (s >= {1'b0, DEG_FULL}) ? 9'(s - {1'b0, DEG_FULL}) : s[8:0];
  endfunction

  function automatic logic crossed(input logic [8:0] p, input logic [8:0] c,
                                   input logic [8:0] a);
    crossed = (p <= c) ? (a > p && a <= c) : (a > p || a <= c);
  endfunction

  function automatic logic [24:0] scale(input logic [15:0] v, input logic [8:0] p);
    scale = 25'(v) * 25'(p);
  endfunction

  psq_pins_type sync1, s, s_snap;
  psq_state_type state;
  logic [MSW-1:0] ms_cnt;
  logic tick, jog, single, all_on, pend, engaged, released, stop_hit;
  logic [8:0] prev_pos, best_ang, top_ang;
  logic [11:0] best_spd, top_spd, sel_spd, base, tgt, rate_ext;
  logic best_hit, any_ang, creep_seen, up;
  logic [15:0] max_spm, stop_ms, clutch_cool, brake_cool;
  logic [7:0] rate;
  logic [NUM_TMR-1:0] cond, fired, hit_sel;
  logic [NUM_TMR-1:0][15:0] lim, tcnt;
  logic t_hit, cool_hit, raise, fr_prev, clr_prev, fr_edge, clr_edge;
  logic [8:0] t_code, new_code;

  // ==========================================================
  // Pin synchronisers and ms timebase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1 <= '0;
      s <= '0;
    end else if (i_ce) begin
      sync1 <= i_pins;
      s <= sync1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ms_cnt <= '0;
    end else if (i_ce) begin
      ms_cnt <= tick ? '0 : ms_cnt + MSW'(1);
    end
  end

  assign tick = i_ce && (ms_cnt == MSW'(P_CYC_PER_MS - 1));
  assign jog = s.inch || s.micro_inch;
  assign single = !s.continuous && !jog;
  assign all_on = s.enable_lo && s.enable_hi && s.clutch_on;
  assign engaged = (state == ST_RUN);
  assign pend = (state == ST_IDLE) && (s.enable_lo || s.enable_hi || s.clutch_on) && !all_on;

  // ==========================================================
  // Position and speed selection
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_position <= '0;
      prev_pos <= '0;
    end else if (i_ce) begin
      o_position <= wrap_deg({1'b0, i_resolver_deg} + {1'b0, i_profile.offset});
      prev_pos <= o_position;
    end
  end

  always_comb begin
    best_hit = 1'b0;
    any_ang = 1'b0;
    best_ang = '0;
    top_ang = '0;
    best_spd = '0;
    top_spd = '0;
    for (int k = 0; k < NUM_PAIRS; k++) begin
      if (i_profile.angle[k] < DEG_FULL) begin
        if (!any_ang || i_profile.angle[k] >= top_ang) begin
          top_ang = i_profile.angle[k];
          top_spd = i_profile.speed[k];
        end
        any_ang = 1'b1;
        if (i_profile.angle[k] <= o_position && (!best_hit || i_profile.angle[k] >= best_ang)) begin
          best_hit = 1'b1;
          best_ang = i_profile.angle[k];
          best_spd = i_profile.speed[k];
        end
      end
    end
    sel_spd = best_hit ? best_spd : top_spd;
  end

  assign stop_hit = engaged && single && crossed(prev_pos, o_position, i_profile.stop_angle);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      creep_seen <= 1'b0;
    end else if (i_ce) begin
      if (!engaged) begin
        creep_seen <= 1'b0;
      end else if (single && crossed(prev_pos, o_position, i_profile.creep_angle)) begin
        creep_seen <= 1'b1;
      end
    end
  end

  always_comb begin
    max_spm = (i_profile.gear == 8'h00) ? i_profile.max_rpm
            : i_profile.max_rpm / {8'h00, i_profile.gear};
    base = '0;
    if (engaged) begin
      if (s.micro_inch) begin
        base = i_profile.micro_speed;
      end else if (s.inch) begin
        base = i_profile.inch_speed;
      end else if (single && creep_seen) begin
        base = i_profile.creep_speed;
      end else begin
        base = sel_spd;
      end
    end
    tgt = ({4'h0, base} > max_spm) ? max_spm[11:0] : base;
  end

  // ==========================================================
  // Run and stop sequence
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      s_snap <= '0;
    end else if (i_ce) begin
      unique case (state)
        ST_IDLE: if (all_on && !o_fault_active) begin
          state <= ST_RUN;
          s_snap <= s;
        end
        ST_RUN: if (!s.enable_lo || !s.enable_hi || raise || stop_hit) begin
          state <= ST_STOP;
        end
        ST_STOP: if (released && !s.contactor_fb && !(s.enable_lo && s.enable_hi)) begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stop_ms <= '0;
    end else if (i_ce) begin
      if (state != ST_STOP) begin
        stop_ms <= '0;
      end else if (tick && stop_ms < i_times.contactor_release_delay) begin
        stop_ms <= stop_ms + 16'h0001;
      end
    end
  end

  assign released = (state == ST_STOP)
                 && (stop_ms >= i_times.contactor_release_delay || !s.clutch_on);
  assign o_clutch_contactor = engaged || (state == ST_STOP && !released);
  assign o_normal_stop = (state == ST_STOP);

  // ==========================================================
  // Setpoint ramp
  assign up = tgt > o_setpoint;
  assign rate_ext = {4'h0, rate};

  always_comb begin
    if (state == ST_STOP) begin
      rate = i_rates.stop_dec;
    end else if (jog) begin
      rate = up ? i_rates.inch_acc : i_rates.inch_dec;
    end else begin
      rate = up ? i_rates.auto_acc : i_rates.auto_dec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_setpoint <= '0;
    end else if (tick) begin
      if (rate >= RATE_STEP) begin
        o_setpoint <= tgt;
      end else if (up) begin
        o_setpoint <= (tgt - o_setpoint > rate_ext) ? o_setpoint + rate_ext : tgt;
      end else begin
        o_setpoint <= (o_setpoint - tgt > rate_ext) ? o_setpoint - rate_ext : tgt;
      end
    end
  end

  // ==========================================================
  // Fault timers
  always_comb begin
    cond[0] = !s.brake_contactor_fb;
    cond[1] = pend && !s.enable_lo;
    cond[2] = pend && !s.enable_hi;
    cond[3] = pend && !s.clutch_on;
    cond[4] = engaged && !s.clutch_on;
    cond[5] = engaged && !s.contactor_fb;
    cond[6] = (state != ST_STOP) && s.contactor_fb && !s.clutch_on;
    cond[7] = (state == ST_STOP) && s.contactor_fb;
    cond[8] = released && s.contactor_fb;
    cond[9] = s.inch && s.micro_inch;
    cond[10] = s.reverse && !jog;
    cond[11] = engaged && (s.inch != s_snap.inch);
    cond[12] = engaged && (s.micro_inch != s_snap.micro_inch);
    cond[13] = engaged && (s.reverse != s_snap.reverse);
    cond[14] = i_meas.clutch_cur > i_meas.clutch_rating;
    cond[15] = i_meas.brake_cur > i_meas.brake_rating;
    cond[16] = scale(i_meas.clutch_cur, PCT_FULL) > scale(i_meas.clutch_rating, PCT_OVERLAP)
            && scale(i_meas.brake_cur, PCT_FULL) > scale(i_meas.brake_rating, PCT_OVERLAP);
    cond[17] = scale(i_meas.clutch_cur, PCT_FULL)
             > scale(i_meas.clutch_rating, {1'b0, i_times.engage_long_pct});
    cond[18] = scale(i_meas.brake_cur, PCT_FULL)
             > scale(i_meas.brake_rating, {1'b0, i_times.stop_long_pct});
    cond[19] = engaged && scale({4'h0, i_meas.speed}, PCT_FULL)
             > scale({4'h0, o_setpoint}, PCT_FULL + {1'b0, i_times.overspeed_pct});
    cond[20] = engaged && scale({4'h0, i_meas.speed}, PCT_FULL)
             < scale({4'h0, o_setpoint}, PCT_FULL - {1'b0, i_times.underspeed_pct});
    lim[0] = i_times.stop_contactor_loss_time;
    lim[1] = i_times.start_handshake_window;
    lim[2] = i_times.start_handshake_window;
    lim[3] = i_times.start_handshake_window;
    lim[4] = i_times.run_signal_loss_time;
    lim[5] = i_times.run_signal_loss_time;
    lim[6] = i_times.run_signal_loss_time;
    lim[7] = i_times.contactor_release_long_limit;
    lim[8] = i_times.contactor_release_short_limit;
    for (int k = 9; k < 14; k++) begin
      lim[k] = i_times.jog_command_change_time;
    end
    lim[14] = i_times.engage_overcurrent_time;
    lim[15] = i_times.stop_overcurrent_time;
    lim[16] = i_times.coil_overlap_time;
    lim[17] = i_times.engage_current_long_time;
    lim[18] = i_times.stop_current_long_time;
    lim[19] = i_times.overspeed_trip_time;
    lim[20] = i_times.underspeed_trip_time;
  end

  always_comb begin
    t_hit = 1'b0;
    t_code = '0;
    hit_sel = '0;
    for (int k = NUM_TMR - 1; k >= 0; k--) begin
      if (tick && cond[k] && !fired[k] && tcnt[k] >= lim[k]) begin
        t_hit = 1'b1;
        t_code = TMR_CODE[k];
        hit_sel = '0;
        hit_sel[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tcnt <= '0;
      fired <= '0;
    end else if (tick) begin
      for (int k = 0; k < NUM_TMR; k++) begin
        if (!cond[k]) begin
          tcnt[k] <= '0;
          fired[k] <= 1'b0;
        end else begin
          if (tcnt[k] < lim[k]) begin
            tcnt[k] <= tcnt[k] + 16'h0001;
          end
          if (hit_sel[k]) begin
            fired[k] <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Cool-down and fault record
  assign fr_edge = i_ce && s.fault_reset && !fr_prev;
  assign clr_edge = i_ce && i_clear_fault && !clr_prev;
  assign cool_hit = fr_edge && (clutch_cool != '0 || brake_cool != '0);
  assign raise = t_hit || cool_hit;
  assign new_code = t_hit ? t_code : ((clutch_cool != '0) ? F_CL_COOL : F_BR_COOL);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clutch_cool <= '0;
      brake_cool <= '0;
      fr_prev <= 1'b0;
      clr_prev <= 1'b0;
    end else if (i_ce) begin
      fr_prev <= s.fault_reset;
      clr_prev <= i_clear_fault;
      if (t_hit && (t_code == F_CL_OVER || t_code == F_CL_LONG)) begin
        clutch_cool <= i_times.clutch_cool_time;
      end else if (tick && clutch_cool != '0) begin
        clutch_cool <= clutch_cool - 16'h0001;
      end
      if (t_hit && (t_code == F_BR_OVER || t_code == F_BR_LONG)) begin
        brake_cool <= i_times.brake_cool_time;
      end else if (tick && brake_cool != '0) begin
        brake_cool <= brake_cool - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fault_hist <= '0;
      o_fault_active <= 1'b0;
    end else if (raise) begin
      o_fault_hist <= {o_fault_hist[HIST-2:0], new_code};
      o_fault_active <= 1'b1;
    end else if (clr_edge || fr_edge) begin
      if (o_fault_active) begin
        o_fault_active <= 1'b0;
      end else if (clr_edge) begin
        o_fault_hist <= '0;
      end
    end
  end

  // ==========================================================
  // Checks
  a_pos_range: assert property (@(posedge i_clk) disable iff (i_rst)
    o_position < DEG_FULL) else $error("position out of range");
  a_spm_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
    {4'h0, tgt} <= max_spm || max_spm > 16'h0FFF) else $error("target above max");
  a_step_rate: assert property (@(posedge i_clk) disable iff (i_rst)
    tick && rate >= RATE_STEP |=> o_setpoint == $past(tgt)) else $error("no step");
  a_hist_shift: assert property (@(posedge i_clk) disable iff (i_rst)
    raise |=> o_fault_hist[0] == $past(new_code) && o_fault_hist[4] == $past(o_fault_hist[3])
    && o_fault_active) else $error("history shift wrong");
  a_clear_hist: assert property (@(posedge i_clk) disable iff (i_rst)
    clr_edge && !o_fault_active && !raise |=> o_fault_hist == '0) else $error("not erased");
  a_clear_act: assert property (@(posedge i_clk) disable iff (i_rst)
    clr_edge && o_fault_active && !raise |=> !o_fault_active && $stable(o_fault_hist))
    else $error("active not cleared");
  a_run_needs: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_IDLE && i_ce && all_on && !o_fault_active |=> engaged) else $error("no run");
  a_release: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_STOP && !s.clutch_on |-> !o_clutch_contactor) else $error("contactor held");
  a_cool_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    cool_hit && !t_hit && clutch_cool != '0 |=> o_fault_hist[0] == F_CL_COOL && o_fault_active)
    else $error("cool-down fault missing");
  a_fire_once: assert property (@(posedge i_clk) disable iff (i_rst)
    t_hit && hit_sel[0] |=> fired[0] || !$past(cond[0])) else $error("timer refires");
endmodule

// *** dv/psq_core_tb.sv ***
// Self-checking bench of the press stroke sequencer
`timescale 1ns/10ps
module psq_core_tb;
  import psq_pkg::*;
  localparam int MS = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] start = 3'h0;
  logic continuous = 1'b1;
  logic reset_req = 1'b0;
  logic brake_ok = 1'b1;
  logic clear_fault = 1'b0;
  logic [2:0] jog = 3'h0;
  logic ce = 1'b1;
  logic [8:0] resolver = 9'h12C;
  psq_pins_type pins;
  psq_meas_type meas;
  psq_profile_type prof;
  psq_rate_type rates;
  psq_times_type tim;
  logic [8:0] position;
  logic [11:0] setpoint;
  logic contactor;
  logic normal_stop;
  logic fault_active;
  logic [HIST-1:0][8:0] hist;
  int mismatches = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  psq_press_ctl psq_press_ctl_i (.i_clk(clk), .i_start(start), .i_continuous(continuous),
    .i_reset_req(reset_req), .i_brake_ok(brake_ok), .i_jog(jog), .i_contactor(contactor),
    .o_pins(pins));
  psq_core #(.P_CYC_PER_MS(MS)) psq_core_i (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_pins(pins), .i_resolver_deg(resolver), .i_meas(meas), .i_profile(prof),
    .i_rates(rates), .i_times(tim), .i_clear_fault(clear_fault), .o_position(position),
    .o_setpoint(setpoint), .o_clutch_contactor(contactor), .o_normal_stop(normal_stop),
    .o_fault_active(fault_active), .o_fault_hist(hist));
  // ==========================================================
  // Shared tasks
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic chk_hist(input logic [HIST-1:0][8:0] exp);
    n_compared++;
    if (hist !== exp) begin
      mismatches++;
      $display("BAD %0t history got %0h want %0h", $time, hist, exp);
    end
  endtask
  task automatic wait_sig(input bit sel, input logic v);
    int n;
    for (n = 0; n < 600; n++) begin
      if ((sel ? contactor : fault_active) === v) break;
      @(negedge clk);
    end
    if (n == 600) begin
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic pulse(input bit pin);
    if (pin) reset_req = 1'b1;
    else clear_fault = 1'b1;
    repeat (4) @(negedge clk);
    reset_req = 1'b0;
    clear_fault = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    repeat (6) @(negedge clk);
    chk_val(12'(contactor), 12'h000, "contactor in reset");
    chk_hist('0);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_val(12'(position), 12'h028, "offset position");
  endtask
  task automatic t_profile();
    start = 3'h7;
    wait_sig(1'b1, 1'b1);
    repeat (2 * MS) @(negedge clk);
    chk_val(setpoint, 12'h014, "ramp rising");
    repeat (10 * MS) @(negedge clk);
    chk_val(setpoint, 12'h032, "first pair speed");
    resolver = 9'h10E;
    repeat (10 * MS) @(negedge clk);
    chk_val(setpoint, 12'h03C, "last valid angle, clamped");
  endtask
  task automatic t_single();
    continuous = 1'b0;
    repeat (4) @(negedge clk);
    resolver = 9'h0D2;
    repeat (3 * MS) @(negedge clk);
    chk_val(setpoint, 12'h00A, "creep speed");
    chk_val(12'(normal_stop), 12'h000, "no stop before stop angle");
    resolver = 9'h0FF;
    repeat (6) @(negedge clk);
    chk_val(12'(normal_stop), 12'h001, "stop at stop angle");
    chk_val(12'(contactor), 12'h001, "contactor held in delay");
    chk_val(setpoint, 12'h000, "instant stop ramp");
    wait_sig(1'b1, 1'b0);
    start = 3'h0;
    continuous = 1'b1;
    repeat (20) @(negedge clk);
    chk_val(12'(normal_stop), 12'h000, "back to idle");
  endtask
  task automatic t_window();
    start = 3'h3;
    wait_sig(1'b0, 1'b1);
    chk_val(12'(hist[0]), 12'h0D2, "missing low enable");
    chk_val(12'(contactor), 12'h000, "no run on fault");
    start = 3'h0;
    pulse(1'b1);
    chk_val(12'(fault_active), 12'h000, "reset clears active");
  endtask
  task automatic t_brake();
    brake_ok = 1'b0;
    repeat (2 * MS) @(negedge clk);
    chk_val(12'(fault_active), 12'h000, "loss timer early");
    wait_sig(1'b0, 1'b1);
    chk_hist({27'h0, 9'h0D2, 9'h0E5});
    brake_ok = 1'b1;
    pulse(1'b0);
  endtask
  task automatic t_cool();
    meas.clutch_cur = 16'h0096;
    wait_sig(1'b0, 1'b1);
    chk_val(12'(hist[0]), 12'h13B, "clutch over rating");
    meas.clutch_cur = 16'h0000;
    pulse(1'b1);
    repeat (2 * MS) @(negedge clk);
    chk_val(12'(hist[0]), 12'h0E3, "reset in cool-down");
    chk_val(12'(fault_active), 12'h001, "cool-down fault active");
  endtask
  task automatic t_erase();
    pulse(1'b0);
    chk_val(12'(fault_active), 12'h000, "clear active");
    chk_val(12'(hist[0]), 12'h0E3, "history kept");
    pulse(1'b0);
    chk_hist('0);
  endtask
  task automatic t_misc();
    jog = 3'h6;
    wait_sig(1'b0, 1'b1);
    chk_val(12'(hist[0]), 12'h0D3, "inch with micro inch");
    jog = 3'h0;
    pulse(1'b0);
    meas.clutch_cur = 16'h001E;
    meas.brake_cur = 16'h001E;
    wait_sig(1'b0, 1'b1);
    chk_val(12'(hist[0]), 12'h13A, "coil current overlap");
    chk_val(12'(hist[1]), 12'h0D3, "older fault shifted");
    meas.clutch_cur = 16'h0000;
    meas.brake_cur = 16'h0000;
    ce = 1'b0;
    resolver = 9'h000;
    repeat (8) @(negedge clk);
    chk_val(12'(position), 12'h163, "frozen by clock enable");
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk_val(12'(position), 12'h064, "offset at zero");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    prof = '0;
    prof.angle[0] = 9'h01E;
    prof.angle[1] = 9'h0C8;
    for (int k = 2; k < NUM_PAIRS; k++) begin
      prof.angle[k] = 9'h168;
    end
    prof.speed[0] = 12'h032;
    prof.speed[1] = 12'h050;
    prof.speed[2] = 12'h014;
    prof.creep_angle = 9'h12C;
    prof.creep_speed = 12'h00A;
    prof.stop_angle = 9'h15E;
    prof.offset = 9'h064;
    prof.gear = 8'h19;
    prof.max_rpm = 16'h05DC;
    rates = '{8'h0A, 8'hC8, 8'h0A, 8'hC8, 8'hC8};
    meas = '{16'h0000, 16'h0064, 16'h0000, 16'h0064, 12'h000};
    tim = '0;
    tim.stop_contactor_loss_time = 16'h0003;
    tim.start_handshake_window = 16'h0005;
    tim.run_signal_loss_time = 16'h0005;
    tim.contactor_release_long_limit = 16'h0014;
    tim.contactor_release_short_limit = 16'h0002;
    tim.jog_command_change_time = 16'h0005;
    tim.engage_overcurrent_time = 16'h0002;
    tim.engage_current_long_time = 16'h0064;
    tim.contactor_release_delay = 16'h0003;
    tim.clutch_cool_time = 16'h0032;
    tim.engage_long_pct = 8'h1E;
    tim.stop_long_pct = 8'h1E;
    tim.overspeed_pct = 8'hFF;
    tim.underspeed_pct = 8'h64;
    t_reset();
    t_profile();
    t_single();
    t_window();
    t_brake();
    t_cool();
    t_erase();
    t_misc();
    close_out();
  end
endmodule

// *** dv/psq_press_ctl.sv ***
// Press control model driving the command pins of the sequencer
`timescale 1ns/10ps
module psq_press_ctl (
  // Clock
  input wire logic i_clk,
  // Commands from the bench
  input wire logic [2:0] i_start,
  input wire logic i_continuous,
  input wire logic i_reset_req,
  input wire logic i_brake_ok,
  input wire logic [2:0] i_jog,
  // Contactor coil from the sequencer
  input wire logic i_contactor,
  // Pins to the sequencer
  output psq_pkg::psq_pins_type o_pins
);
  import psq_pkg::*;
  logic contactor_closed = 1'b0;
  // ==========================================================
  // Contactor feedback
  always_ff @(negedge i_clk) begin
    contactor_closed <= i_contactor;
  end
  assign o_pins.contactor_fb = contactor_closed;
  assign o_pins.brake_contactor_fb = i_brake_ok;
  // ==========================================================
  // Start, jog, mode and reset commands
  assign o_pins.enable_lo = i_start[2];
  assign o_pins.enable_hi = i_start[1];
  assign o_pins.clutch_on = i_start[0];
  assign o_pins.inch = i_jog[2];
  assign o_pins.micro_inch = i_jog[1];
  assign o_pins.reverse = i_jog[0];
  assign o_pins.continuous = i_continuous;
  assign o_pins.fault_reset = i_reset_req;
endmodule

// *** include/psq_pkg.sv ***
// Constants and carrier types of the press stroke sequencer
// ==========================================================
// What this block does
// - Run at the speed paired with the last of six angles passed.
// - An angle of exactly 360 degrees is unused.
// - Single stroke: after the creep angle, command creep speed.
// - Single stroke: after the stop angle, do a normal stop.
// - Add a 0-360 degree offset to the resolver position.
// - Clamp every speed to max RPM divided by gear ratio.
// - Ramp at auto, inch and stop rates; a rate of 200 or more steps at once.
// - Keep the active fault and four earlier ones, each readable.
// - Clear request clears the active fault, else erases the history.
// - Brake contactor lost beyond its time raises 229.
// - Enables and clutch-on must meet in a window: else 210, 213, 208.
// - While running, lost clutch-on 208, lost contactor 218; outside stop, stray contactor 209.
// - Stop: contactor release taking too long raises 223.
// - Stop: contactor still closed past the short limit after release raises 225.
// - Jog commands changed while engaged or illegal raise 211, 212, 317-319.
// - Clutch over rating raises 315, brake over rating 316.
// - Both currents above 20% too long raises 314.
// - Clutch current above its percentage too long raises 320.
// - Brake current above its percentage too long raises 321.
// - Speed above setpoint by a percentage too long raises 101.
// - Speed below setpoint by a margin too long raises 313.
// - After stop, release contactor after a delay; clutch-on loss overrides.
// - Fault reset during coil cool-down raises a new fault.
package psq_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int NUM_PAIRS = 6;
  localparam int HIST = 5;
  localparam int NUM_TMR = 21;
  localparam logic [8:0] DEG_FULL = 9'h168;
  localparam logic [7:0] RATE_STEP = 8'hC8;
  localparam logic [8:0] PCT_FULL = 9'h064;
  localparam logic [8:0] PCT_OVERLAP = 9'h014;
  localparam logic [8:0] F_CL_COOL = 9'h0E3;
  localparam logic [8:0] F_BR_COOL = 9'h0E4;
  localparam logic [8:0] F_CL_OVER = 9'h13B;
  localparam logic [8:0] F_BR_OVER = 9'h13C;
  localparam logic [8:0] F_CL_LONG = 9'h140;
  localparam logic [8:0] F_BR_LONG = 9'h141;
  // Fault code of each timer, index 20 first
  localparam logic [NUM_TMR-1:0][8:0] TMR_CODE = {
    9'h139, 9'h065, F_BR_LONG, F_CL_LONG, 9'h13A, F_BR_OVER, F_CL_OVER,
    9'h13F, 9'h13E, 9'h13D, 9'h0D4, 9'h0D3, 9'h0E1, 9'h0DF,
    9'h0D1, 9'h0DA, 9'h0D0, 9'h0D0, 9'h0D5, 9'h0D2, 9'h0E5};

  typedef struct packed {
    logic enable_lo;
    logic enable_hi;
    logic clutch_on;
    logic inch;
    logic micro_inch;
    logic reverse;
    logic continuous;
    logic fault_reset;
    logic contactor_fb;
    logic brake_contactor_fb;
  } psq_pins_type;

  typedef struct packed {
    logic [NUM_PAIRS-1:0][8:0] angle;
    logic [NUM_PAIRS-1:0][11:0] speed;
    logic [8:0] creep_angle;
    logic [11:0] creep_speed;
    logic [8:0] stop_angle;
    logic [8:0] offset;
    logic [7:0] gear;
    logic [15:0] max_rpm;
    logic [11:0] inch_speed;
    logic [11:0] micro_speed;
  } psq_profile_type;

  typedef struct packed {
    logic [7:0] auto_acc;
    logic [7:0] auto_dec;
    logic [7:0] inch_acc;
    logic [7:0] inch_dec;
    logic [7:0] stop_dec;
  } psq_rate_type;

  typedef struct packed {
    logic [15:0] stop_contactor_loss_time;
    logic [15:0] start_handshake_window;
    logic [15:0] run_signal_loss_time;
    logic [15:0] contactor_release_long_limit;
    logic [15:0] contactor_release_short_limit;
    logic [15:0] jog_command_change_time;
    logic [15:0] engage_overcurrent_time;
    logic [15:0] stop_overcurrent_time;
    logic [15:0] coil_overlap_time;
    logic [15:0] engage_current_long_time;
    logic [15:0] stop_current_long_time;
    logic [15:0] overspeed_trip_time;
    logic [15:0] underspeed_trip_time;
    logic [15:0] contactor_release_delay;
    logic [15:0] clutch_cool_time;
    logic [15:0] brake_cool_time;
    logic [7:0] engage_long_pct;
    logic [7:0] stop_long_pct;
    logic [7:0] overspeed_pct;
    logic [7:0] underspeed_pct;
  } psq_times_type;

  typedef struct packed {
    logic [15:0] clutch_cur;
    logic [15:0] clutch_rating;
    logic [15:0] brake_cur;
    logic [15:0] brake_rating;
    logic [11:0] speed;
  } psq_meas_type;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} psq_state_type;
endpackage
